// ---- logic/aserc_core.sv ----
`timescale 1ns/1ps
`default_nettype none
module aserc_core (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        ce,
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        rx_pin,
    output logic             tx_pin,
    output logic             tx_oe
);
    logic [7:0]  ctrl;
    logic [12:0] baud_div;
    logic [12:0] baud_cnt;
    logic        rx_ff1;
    logic        rx_ff2;
    logic [3:0]  tx_ph;
    logic [3:0]  tx_bits;
    logic [13:0] tx_sh;
    logic [7:0]  tx_buf;
    logic        tx_buffer_empty_flag;
    logic        tc;
    logic        brk_q;
    logic        idle_q;
    logic [7:0]  rx_buf;
    logic        rx_b8;
    logic        rx_buffer_full_flag;
    logic        ovr;
    logic        nf;
    logic        fe;
    logic [3:0]  arm;
    logic        arm_tx;
    aserc_pkg::aserc_rx_state_t rx_st;
    logic [2:0]  hist;
    logic [3:0]  rx_ph;
    logic [3:0]  rx_idx;
    logic [1:0]  zcnt;
    logic        rx_s8;
    logic        rx_s9;
    logic        rx_noise;
    logic        rx_zero;
    logic [8:0]  rx_sh;
    logic        rx_done;
    logic        rx_dfe;
    logic        rx_dnf;
    logic [8:0]  rx_word;

    // Bus decode; a request is taken on the edge where waitrequest is still high.
    wire take    = ce & (avs_read | avs_write) & avs_waitrequest;
    wire rd      = take & avs_read;
    wire wr      = take & avs_write;
    wire data_rd = rd & (avs_address == aserc_pkg::ADDR_DATA);
    wire stat_rd = rd & (avs_address == aserc_pkg::ADDR_STAT);
    wire data_wr = wr & (avs_address == aserc_pkg::ADDR_DATA);
    wire ctrl_wr = wr & (avs_address == aserc_pkg::ADDR_CTRL);
    wire baud_wr = wr & (avs_address == aserc_pkg::ADDR_BAUD);

    // Control fields.
    wire tx_on   = ctrl[aserc_pkg::C_TX_ON];
    wire rx_on   = ctrl[aserc_pkg::C_RX_ON];
    wire send_break_bit     = ctrl[aserc_pkg::C_BREAK];
    wire longbk  = ctrl[aserc_pkg::C_LONGBK];
    wire nine    = ctrl[aserc_pkg::C_NINE];
    wire tx_inv  = ctrl[aserc_pkg::C_TX_INVERT];
    wire rx_inv  = ctrl[aserc_pkg::C_RX_INVERT];
    wire new_te  = avs_writedata[aserc_pkg::C_TX_ON];
    wire new_sbk = avs_writedata[aserc_pkg::C_BREAK];

    // Status word and read mux; unmapped addresses read as zero.
    wire [7:0] stat_val = {tx_buffer_empty_flag, tc, rx_buffer_full_flag, 1'b0, ovr, nf, fe, 1'b0};
    wire [31:0] rd_val =
        (avs_address == aserc_pkg::ADDR_DATA) ? {23'h000000, rx_b8, rx_buf} :
        (avs_address == aserc_pkg::ADDR_STAT) ? {24'h000000, stat_val} :
        (avs_address == aserc_pkg::ADDR_CTRL) ? {24'h000000, ctrl} :
        (avs_address == aserc_pkg::ADDR_BAUD) ? {19'h00000, baud_div} :
        32'h00000000;

    // Answer one cycle after the request is taken, then drop back to busy.
    always_ff @(posedge clk) begin
        if (rst) begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h00000000;
        end else if (ce) begin
            avs_waitrequest <= ~take;
            if (rd) begin
                avs_readdata <= rd_val;
            end
        end
    end

    // Software-written control and divisor.
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl     <= aserc_pkg::CTRL_RST;
            baud_div <= aserc_pkg::BAUD_RST;
        end else if (ce) begin
            if (ctrl_wr) begin
                ctrl <= avs_writedata[7:0];
            end
            if (baud_wr) begin
                baud_div <= avs_writedata[12:0];
            end
        end
    end

    // R2: shared baud tick
    // One tick every baud_div clocks at sixteen times the bit rate; zero divides slowest.
    wire baud_tick = (baud_cnt == 13'h0000);
    always_ff @(posedge clk) begin
        if (rst) begin
            baud_cnt <= 13'h0000;
        end else if (ce) begin
            baud_cnt <= baud_tick ? baud_div - 13'h0001 : baud_cnt - 13'h0001;
        end
    end

    // Pin synchroniser; only the second stage is read.
    always_ff @(posedge clk) begin
        if (rst) begin
            rx_ff1 <= 1'b1;
            rx_ff2 <= 1'b1;
        end else if (ce) begin
            rx_ff1 <= rx_pin;
            rx_ff2 <= rx_ff1;
        end
    end

    // Transmit bit timing and lengths.
    wire       bit_tick = baud_tick & (tx_ph == aserc_pkg::RT16);
    wire       tx_busy  = (tx_bits != 4'h0);
    wire       tx_free  = (tx_bits <= 4'h1);
    wire       tx_last  = bit_tick & (tx_bits == 4'h1);
    // R5: frame length select
    wire [3:0] frame_len = nine ? aserc_pkg::FRAME9 : aserc_pkg::FRAME8;
    // R10: break length select
    wire [3:0] brk_len =
        ({longbk, nine} == 2'b00) ? aserc_pkg::BRK_00 :
        ({longbk, nine} == 2'b01) ? aserc_pkg::BRK_01 :
        ({longbk, nine} == 2'b10) ? aserc_pkg::BRK_10 : aserc_pkg::BRK_11;
    // R14: start zero, data LSB first, stop one
    wire [13:0] data_frame = nine ?
        {3'h7, 1'b1, ctrl[aserc_pkg::C_T8], tx_buf, 1'b0} :
        {4'hf, 1'b1, tx_buf, 1'b0};
    // Load choice at a free bit boundary: break, then idle, then data.
    wire ld_brk  = bit_tick & tx_free & brk_q;
    wire ld_idle = bit_tick & tx_free & ~brk_q & idle_q;
    wire ld_data = bit_tick & tx_free & ~brk_q & ~idle_q & tx_on & ~tx_buffer_empty_flag;
    wire ld_any  = ld_brk | ld_idle | ld_data;
    // R9: break queued on one-then-zero
    wire brk_ev  = ctrl_wr & send_break_bit & ~new_sbk;
    // R4: preamble on enable
    // R11: idle queued on zero-then-one
    wire idle_ev = ctrl_wr & ~tx_on & new_te;

    always_ff @(posedge clk) begin
        if (rst) begin
            tx_ph <= 4'h0;
        end else if (ce & baud_tick) begin
            tx_ph <= tx_ph + 4'h1;
        end
    end

    // R6: load aligned to bit tick
    always_ff @(posedge clk) begin
        if (rst) begin
            tx_bits <= 4'h0;
            tx_sh   <= 14'h3fff;
        end else if (ce & bit_tick) begin
            if (ld_brk) begin
                tx_sh   <= 14'h0000;
                tx_bits <= brk_len;
            end else if (ld_idle) begin
                tx_sh   <= 14'h3fff;
                tx_bits <= frame_len;
            end else if (ld_data) begin
                tx_sh   <= data_frame;
                tx_bits <= frame_len;
            end else if (tx_busy) begin
                tx_sh   <= {1'b1, tx_sh[13:1]};
                tx_bits <= tx_bits - 4'h1;
            end
        end
    end

    // Queues; a new request wins over the consumption in the same cycle.
    always_ff @(posedge clk) begin
        if (rst) begin
            brk_q  <= 1'b0;
            idle_q <= 1'b0;
        end else if (ce) begin
            // R9: re-queue while held
            brk_q  <= brk_ev | (ld_brk ? send_break_bit : brk_q);
            idle_q <= idle_ev | (idle_q & ~ld_idle);
        end
    end

    // Transmit buffer and flags; a status read arms the empty flag for clearing.
    always_ff @(posedge clk) begin
        if (rst) begin
            tx_buf <= aserc_pkg::DATA_RST;
            tx_buffer_empty_flag   <= 1'b1;
            tc     <= 1'b1;
            arm_tx <= 1'b0;
        end else if (ce) begin
            // R1: write goes to transmit buffer
            if (data_wr) begin
                tx_buf <= avs_writedata[7:0];
            end
            if (stat_rd) begin
                arm_tx <= tx_buffer_empty_flag;
            end else if (data_wr) begin
                arm_tx <= 1'b0;
            end
            // R6: empty flag set on load
            tx_buffer_empty_flag <= ld_data | (tx_buffer_empty_flag & ~(data_wr & arm_tx));
            // R7: complete when nothing waits
            tc   <= (tx_last & ~ld_any) | (tc & ~ld_any & ~data_wr & ~idle_ev & ~brk_ev);
        end
    end

    // R3: idle high, optional inversion
    // R8: pin kept while work remains
    always_ff @(posedge clk) begin
        if (rst) begin
            tx_pin <= 1'b1;
            tx_oe  <= 1'b0;
        end else if (ce) begin
            tx_pin <= tx_inv ^ (tx_busy ? tx_sh[0] : 1'b1);
            tx_oe  <= tx_on | tx_busy | brk_q | idle_q;
        end
    end

    // R13: input inversion
    wire       rx_s    = rx_ff2 ^ rx_inv;
    // R16: three ones then zero
    wire       fedge   = (hist == 3'b111) & ~rx_s;
    wire [3:0] stop_ix = nine ? aserc_pkg::STOP9 : aserc_pkg::STOP8;
    wire       in_fr   = (rx_st == aserc_pkg::RX_FRAME);
    // R18: majority of three samples
    wire       maj     = (rx_s8 & rx_s9) | (rx_s8 & rx_s) | (rx_s9 & rx_s);
    wire       agree   = (rx_s8 == rx_s9) & (rx_s9 == rx_s);
    wire       at_dec  = in_fr & (rx_ph == aserc_pkg::RT10) & (rx_idx != 4'h0);
    wire       at_stop = at_dec & (rx_idx == stop_ix);
    // R20: realign on later edges
    wire       resync  = in_fr & fedge & (rx_ph > aserc_pkg::RT10);
    wire       bit_end = in_fr & ((rx_ph == aserc_pkg::RT16) | resync);
    // R17: two of three zeros
    wire [1:0] zsum    = zcnt + {1'b0, ~rx_s};
    wire       st_bad  = in_fr & (rx_idx == 4'h0) & (rx_ph == aserc_pkg::RT7) & (zsum < 2'h2);
    wire       st_samp = (rx_ph == aserc_pkg::RT3) | (rx_ph == aserc_pkg::RT5) |
                         (rx_ph == aserc_pkg::RT7);
    wire       late    = (rx_ph == aserc_pkg::RT8) | (rx_ph == aserc_pkg::RT9) |
                         (rx_ph == aserc_pkg::RT10);
    // R25: zero stop is framing error
    wire       fr_err  = at_stop & ~maj;
    // R19: noise across whole frame
    wire       nf_fin  = rx_noise | ~agree;

    // Receive sequencer, advanced on each oversample tick while enabled.
    always_ff @(posedge clk) begin
        if (rst | (ce & ~rx_on)) begin
            rx_st <= aserc_pkg::RX_SEARCH;
            hist  <= 3'b000;
            rx_ph <= 4'h0;
        end else if (ce & baud_tick) begin
            // R21: preload ones after non-break error
            hist <= (fr_err & ~(rx_zero & ~maj)) ? 3'b111 : {hist[1:0], rx_s};
            // The edge sample is the first phase itself, so the next tick is the second.
            rx_ph <= (fedge & (resync | ~in_fr)) ? 4'h1 :
                     (bit_end | ~in_fr) ? 4'h0 : rx_ph + 4'h1;
            if (~in_fr & fedge) begin
                rx_st <= aserc_pkg::RX_FRAME;
            end else if (st_bad | at_stop) begin
                rx_st <= aserc_pkg::RX_SEARCH;
            end
        end
    end

    // Bit index, start check and sample capture.
    always_ff @(posedge clk) begin
        if (rst) begin
            rx_idx   <= 4'h0;
            zcnt     <= 2'h0;
            rx_s8    <= 1'b1;
            rx_s9    <= 1'b1;
            rx_noise <= 1'b0;
            rx_zero  <= 1'b1;
            rx_sh    <= 9'h000;
        end else if (ce & baud_tick) begin
            if (~in_fr) begin
                rx_idx   <= 4'h0;
                zcnt     <= 2'h0;
                rx_noise <= 1'b0;
                rx_zero  <= 1'b1;
            end else begin
                if (bit_end) begin
                    rx_idx <= rx_idx + 4'h1;
                end
                if (rx_ph == aserc_pkg::RT8) begin
                    rx_s8 <= rx_s;
                end
                if (rx_ph == aserc_pkg::RT9) begin
                    rx_s9 <= rx_s;
                end
                // R18: start counts as zero
                if (rx_idx == 4'h0) begin
                    if (st_samp) begin
                        zcnt <= zsum;
                    end
                    if (st_samp | late) begin
                        rx_noise <= rx_noise | rx_s;
                    end
                end else if (at_dec) begin
                    rx_noise <= nf_fin;
                    rx_zero  <= rx_zero & ~maj;
                    if (~at_stop) begin
                        rx_sh <= {maj, rx_sh[8:1]};
                    end
                end
            end
        end
    end

    // Completed frame handed to the buffer stage one cycle later.
    always_ff @(posedge clk) begin
        if (rst) begin
            rx_done <= 1'b0;
            rx_dfe  <= 1'b0;
            rx_dnf  <= 1'b0;
            rx_word <= 9'h000;
        end else if (ce) begin
            rx_done <= baud_tick & at_stop;
            if (baud_tick & at_stop) begin
                rx_dfe  <= fr_err;
                rx_dnf  <= nf_fin;
                rx_word <= nine ? rx_sh : {1'b0, rx_sh[8:1]};
            end
        end
    end

    // Transfer outcome for a finished frame.
    // R22: framing flag blocks transfer
    wire xfer = rx_done & ~fe & ~rx_buffer_full_flag;
    // R15: overrun discards character
    wire ovr_set = rx_done & ~fe & rx_buffer_full_flag;
    // R23: two-step clear
    wire [3:0] clr = data_rd ? arm : 4'h0;

    // Receive buffer and flags; a set in the clearing cycle wins.
    always_ff @(posedge clk) begin
        if (rst) begin
            rx_buf <= aserc_pkg::DATA_RST;
            rx_b8  <= 1'b0;
            rx_buffer_full_flag   <= 1'b0;
            ovr    <= 1'b0;
            nf     <= 1'b0;
            fe     <= 1'b0;
            arm    <= 4'h0;
        end else if (ce) begin
            if (stat_rd) begin
                arm <= {rx_buffer_full_flag, ovr, nf, fe};
            end else if (data_rd) begin
                arm <= 4'h0;
            end
            if (xfer) begin
                rx_buf <= rx_word[7:0];
                rx_b8  <= rx_word[8];
            end
            rx_buffer_full_flag <= xfer | (rx_buffer_full_flag & ~clr[3]);
            ovr  <= ovr_set | (ovr & ~clr[2]);
            // R24: errors only with full flag
            nf   <= (xfer & rx_dnf) | (nf & ~clr[1]);
            fe   <= (xfer & rx_dfe) | (fe & ~clr[0]);
        end
    end
endmodule : aserc_core
`default_nettype wire

// ---- logic/aserc_pkg.sv ----
// Notes on behaviour
// R1: Data location reads receive, writes transmit buffer.
// R2: Both directions share one baud tick generator.
// R3: Transmit idles high; tx_invert flips all levels.
// R4: Enabling transmitter queues one idle preamble frame.
// R5: Shifter spans ten or eleven bit times.
// R6: Free shifter loads buffer, sets empty flag.
// R7: Nothing waiting after stop sets complete flag.
// R8: Disabling transmitter finishes the shifter and queued idle or break first; buffered data is not sent.
// R9: Break bit one-then-zero queues break; repeats.
// R10: Break is zeros, 10/11/13/14 bit times.
// R11: Toggling tx_on off-on queues one idle frame.
// R12: Software holds pin high if shifter may finish.
// R13: rx_invert flips input; receiver runs when enabled.
// R14: Frame: zero start, LSB-first data, one stop.
// R15: Full buffer turns new character into overrun.
// R16: Sixteen samples per bit; 1110 is edge.
// R17: Start needs two zeros among phases 3,5,7.
// R18: Bits decided by majority of 8,9,10.
// R19: Any disagreeing sample sets noise on transfer.
// R20: A falling edge after phase 10 realigns the sample phase.
// R21: Non-break framing error preloads three ones.
// R22: Framing flag set blocks all buffer transfers.
// R23: Status read then data read clears full.
// R24: Error flags set with full flag, never overrun.
// R25: Zero stop bit sets the framing flag.
package aserc_pkg;
    // Register byte addresses on the slave bus.
    localparam logic [3:0] ADDR_DATA = 4'h0;
    localparam logic [3:0] ADDR_STAT = 4'h4;
    localparam logic [3:0] ADDR_CTRL = 4'h8;
    localparam logic [3:0] ADDR_BAUD = 4'hc;
    // Control field positions.
    localparam int C_TX_ON  = 0;
    localparam int C_RX_ON  = 1;
    localparam int C_BREAK  = 2;
    localparam int C_LONGBK = 3;
    localparam int C_NINE   = 4;
    localparam int C_TX_INVERT  = 5;
    localparam int C_RX_INVERT  = 6;
    localparam int C_T8     = 7;
    // Status field positions.
    localparam int S_TX_BUFFER_EMPTY_FLAG = 7;
    localparam int S_TC   = 6;
    localparam int S_RX_BUFFER_FULL_FLAG = 5;
    localparam int S_OVR  = 3;
    localparam int S_NF   = 2;
    localparam int S_FE   = 1;
    // Reset values.
    localparam logic [7:0]  CTRL_RST = 8'h00;
    localparam logic [7:0]  DATA_RST = 8'h00;
    localparam logic [12:0] BAUD_RST = 13'h0010;
    // Frame and break lengths in bit times.
    localparam logic [3:0] FRAME8  = 4'ha;
    localparam logic [3:0] FRAME9  = 4'hb;
    localparam logic [3:0] BRK_00  = 4'ha;
    localparam logic [3:0] BRK_01  = 4'hb;
    localparam logic [3:0] BRK_10  = 4'hd;
    localparam logic [3:0] BRK_11  = 4'he;
    // Sample phase indices, value is phase number minus one.
    localparam logic [3:0] RT3  = 4'h2;
    localparam logic [3:0] RT5  = 4'h4;
    localparam logic [3:0] RT7  = 4'h6;
    localparam logic [3:0] RT8  = 4'h7;
    localparam logic [3:0] RT9  = 4'h8;
    localparam logic [3:0] RT10 = 4'h9;
    localparam logic [3:0] RT16 = 4'hf;
    // Index of the stop bit for each data width.
    localparam logic [3:0] STOP8 = 4'h9;
    localparam logic [3:0] STOP9 = 4'ha;
    typedef enum logic [0:0] {RX_SEARCH, RX_FRAME} aserc_rx_state_t;
endpackage : aserc_pkg

// ---- tb/aserc_core_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
module aserc_chk (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        ce,
    input wire logic [3:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic        rx_pin,
    input wire logic        tx_pin,
    input wire logic        tx_oe
);
    logic        inv;
    logic        ton;
    logic [12:0] baud;
    logic [19:0] low_cnt;
    // Taken requests, decoded as the slave decodes them.
    wire         rd_take = ce && avs_read && avs_waitrequest;
    wire         wr_take = ce && avs_write && avs_waitrequest;
    wire         ctl_wr  = wr_take && avs_address == aserc_pkg::ADDR_CTRL;
    wire  [16:0] bit_len = {baud, 4'h0};
    // Shadow the invert, enable and divisor so line checks know idle level and bit time.
    always_ff @(posedge clk) begin
        if (rst) begin
            inv <= 1'b0;
            ton <= 1'b0;
            baud <= aserc_pkg::BAUD_RST;
        end else if (ctl_wr) begin
            inv <= avs_writedata[aserc_pkg::C_TX_INVERT];
            ton <= avs_writedata[aserc_pkg::C_TX_ON];
        end else if (wr_take && avs_address == aserc_pkg::ADDR_BAUD) begin
            baud <= avs_writedata[12:0];
        end
    end
    // Length of the current low run on the line, in clocks.
    always_ff @(posedge clk) begin
        if (rst || tx_pin) begin
            low_cnt <= 20'h0;
        end else begin
            low_cnt <= low_cnt + 20'h1;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    chk_bus_answer: assert property ((rd_take || wr_take) |=> !avs_waitrequest)
        else $error("Taken request got no answer in the next cycle.");
    chk_wait_pulse: assert property ((ce && !avs_waitrequest) |=> avs_waitrequest)
        else $error("Answer lasted more than one cycle.");
    chk_wait_cause: assert property (!avs_waitrequest |-> $past(avs_read || avs_write))
        else $error("Answer without a request.");
    chk_rdata_hold: assert property (!$past(rd_take) |-> $stable(avs_readdata))
        else $error("Read data moved without a read.");
    chk_unmapped_zero: assert property (rd_take && avs_address[1:0] != 2'h0 |=> avs_readdata == 32'h0)
        else $error("Unmapped read returned nonzero.");
    chk_reset_idle: assert property ($fell(rst) |-> tx_pin && !tx_oe)
        else $error("Line not idle high after reset.");
    chk_oe_follows: assert property (ctl_wr && avs_writedata[aserc_pkg::C_TX_ON] |-> ##2 tx_oe)
        else $error("Transmitter did not take the pin.");
    chk_oe_hold: assert property ($fell(tx_oe) |-> !ton && tx_pin == !inv)
        else $error("Pin released while enabled or not idle.");
    chk_bit_length: assert property ($rose(tx_pin) && tx_oe && !inv |-> low_cnt % bit_len == 0)
        else $error("Low run is not a whole number of bit times.");
    cover property (rd_take);
    cover property ($fell(tx_oe));
    cover property ($rose(tx_pin) && tx_oe);
endmodule : aserc_chk
bind aserc_core aserc_chk u_chk (.clk(clk), .rst(rst), .ce(ce), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .rx_pin(rx_pin),
    .tx_pin(tx_pin), .tx_oe(tx_oe));
`default_nettype wire

// ---- tb/aserc_peer.sv ----
`timescale 1ns/1ps
`default_nettype none
module aserc_peer #(
    parameter int BIT = 32
) (
    input  wire logic clk,
    input  wire logic line_in,
    output logic      line_out
);
    logic [8:0] got_q[$];
    int         run = 0;
    int         last_run = 0;
    initial line_out = 1'b1;
    // decode frames mid-bit, stop bit kept at bit 8.
    initial begin : rx_loop
        logic [8:0] v;
        forever begin
            @(negedge line_in);
            repeat (BIT / 2) @(posedge clk);
            if (line_in === 1'b0) begin
                for (int i = 0; i < 9; i++) begin
                    repeat (BIT) @(posedge clk);
                    v[i] = line_in;
                end
                got_q.push_back(v);
            end
        end
    end
    // Length of the last low run, so break lengths can be judged.
    always @(posedge clk) begin
        if (!line_in) run <= run + 1;
        else if (run != 0) begin
            last_run <= run;
            run <= 0;
        end
    end
    // zero start, data LSB first, then the asked stop level; g adds one noisy sample.
    task automatic send(input logic [7:0] d, input logic stop, input logic g);
        line_out <= 1'b0;
        repeat (BIT) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            line_out <= d[i];
            if (i == 0 && g) begin
                repeat (BIT / 2) @(posedge clk);
                line_out <= ~d[0];
                repeat (BIT / 16) @(posedge clk);
                line_out <= d[0];
                repeat (BIT * 7 / 16) @(posedge clk);
            end else repeat (BIT) @(posedge clk);
        end
        // A low stop ends early, so the false start the preloaded edge search sees fails the start check.
        line_out <= stop;
        repeat (stop ? BIT : BIT * 3 / 4) @(posedge clk);
        line_out <= 1'b1;
        repeat (2 * BIT) @(posedge clk);
    endtask : send
endmodule : aserc_peer
`default_nettype wire

// ---- tb/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam int N = 2;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [3:0]  avs_address = 4'h0;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        rx_pin;
    logic        tx_pin;
    logic        tx_oe;
    logic [31:0] rdat;
    logic [7:0]  v;
    logic [7:0]  w;
    logic [7:0]  exp_q[$];
    int          blen[4] = '{10, 13, 11, 14};
    int          num_errors = 0;
    int          compares = 0;
    int          seed = 19909;
    always #2 clk = ~clk;
    aserc_core DUT (.clk(clk), .rst(rst), .ce(1'b1), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .rx_pin(rx_pin),
        .tx_pin(tx_pin), .tx_oe(tx_oe));
    // a released line is held high, as software would by the port pin.
    aserc_peer #(.BIT(16 * N)) u_peer (.clk(clk), .line_in(tx_oe ? tx_pin : 1'b1),
        .line_out(rx_pin));
    task automatic end_of_test;
        $display("Counts: %0d compares, %0d mismatches", compares, num_errors);
        if (num_errors == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : end_of_test
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    // One bus transfer, held until waitrequest is sampled low; a hang ends the run.
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        avs_address <= a;
        avs_read <= !wr;
        avs_write <= wr;
        avs_writedata <= d;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        if (n >= 50) begin
            num_errors++;
            $display("ERROR bus answer expected 0 seen 1");
            end_of_test();
        end
        rdat = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus
    // Poll status until bit b is set, with a bound.
    task automatic wait_stat(input int b);
        int n;
        for (n = 0; n < 600; n++) begin
            bus(1'b0, aserc_pkg::ADDR_STAT, 32'h0);
            if (rdat[b] === 1'b1) break;
        end
        if (n == 600) begin
            num_errors++;
            $display("ERROR status bit %0d expected 1 seen 0", b);
            end_of_test();
        end
    endtask : wait_stat
    task automatic rx_read(input string what, input logic [31:0] st, input logic [7:0] d);
        bus(1'b0, aserc_pkg::ADDR_STAT, 32'h0);
        check({what, " status"}, st, rdat);
        bus(1'b0, aserc_pkg::ADDR_DATA, 32'h0);
        check({what, " data"}, {24'h0, d}, rdat);
    endtask : rx_read
    // A hang anywhere is cut short here.
    initial begin
        repeat (100000) @(posedge clk);
        num_errors++;
        $display("ERROR run length expected done seen timeout");
        end_of_test();
    end
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        bus(1'b0, aserc_pkg::ADDR_STAT, 32'h0);
        check("status reset", 32'hc0, rdat);
        bus(1'b0, aserc_pkg::ADDR_DATA, 32'h0);
        check("data reset", 32'h0, rdat);
        bus(1'b0, 4'h2, 32'h0);
        check("unmapped read", 32'h0, rdat);
        $display("test reset done");
        bus(1'b1, aserc_pkg::ADDR_BAUD, N);
        bus(1'b1, aserc_pkg::ADDR_CTRL, 32'h03);
        for (int i = 0; i < 4; i++) begin
            v = 8'($random(seed));
            exp_q.push_back(v);
            wait_stat(aserc_pkg::S_TX_BUFFER_EMPTY_FLAG);
            bus(1'b1, aserc_pkg::ADDR_DATA, {24'h0, v});
        end
        wait_stat(aserc_pkg::S_TC);
        check("tx frames", 4, u_peer.got_q.size());
        while (exp_q.size() > 0) check("tx frame", {1'b1, exp_q.pop_front()}, u_peer.got_q.pop_front());
        $display("test transmit done");
        v = 8'($random(seed));
        w = 8'($random(seed));
        u_peer.send(v, 1'b1, 1'b0);
        u_peer.send(w, 1'b1, 1'b0);
        rx_read("overrun", 32'he8, v);
        bus(1'b0, aserc_pkg::ADDR_STAT, 32'h0);
        check("flags cleared", 32'hc0, rdat);
        u_peer.send(w & 8'hfe, 1'b1, 1'b1);
        rx_read("noise", 32'he4, w & 8'hfe);
        u_peer.send(v, 1'b0, 1'b0);
        rx_read("framing", 32'he2, v);
        u_peer.send(w, 1'b1, 1'b0);
        rx_read("after framing", 32'he0, w);
        $display("test receive done");
        for (int k = 0; k < 4; k++) begin
            bus(1'b1, aserc_pkg::ADDR_CTRL, 32'h07 | (k << 3));
            bus(1'b1, aserc_pkg::ADDR_CTRL, 32'h03 | (k << 3));
            wait_stat(aserc_pkg::S_TC);
            repeat (2) @(posedge clk);
            check("break length", blen[k] * 16 * N, u_peer.last_run);
        end
        u_peer.got_q.delete();
        bus(1'b1, aserc_pkg::ADDR_CTRL, 32'h03);
        u_peer.send(8'h00, 1'b0, 1'b0);
        rx_read("break", 32'he2, 8'h00);
        $display("test break done");
        bus(1'b1, aserc_pkg::ADDR_CTRL, 32'h02);
        for (int n = 0; n < 2000 && tx_oe !== 1'b0; n++) @(posedge clk);
        check("released oe", 32'h0, {31'h0, tx_oe});
        check("released pin", 32'h1, {31'h0, tx_pin});
        bus(1'b1, aserc_pkg::ADDR_CTRL, 32'h22);
        repeat (4) @(posedge clk);
        check("inverted idle", 32'h0, {31'h0, tx_pin});
        $display("test release done");
        end_of_test();
    end
endmodule : tb
`default_nettype wire
